//--- ffc_pkg.sv
// Shared constants, width codes and helpers of the FIFO flag controller
package ffc_pkg;

    // ===================================================================
    // Sizes
    localparam int unsigned PTR_W    = 12;   // Bit-address counters
    localparam int unsigned LVL_W    = 13;   // Fill level, 0..4096 bits
    localparam int unsigned DATA_W   = 18;   // Widest data port
    localparam int unsigned UNIT_W   = 9;    // Stored bits per byte slot
    localparam int unsigned SLOT_SH  = 3;    // Address bits inside a slot
    localparam int unsigned MEM_BITS = 4608; // 512 slots of nine bits
    localparam int unsigned IDX_W    = 13;
    localparam int unsigned WD_W     = 3;
    localparam int unsigned BUF_DEPTH = 8;
    localparam logic [LVL_W-1:0] TOTAL_BITS = 13'h1000;
    localparam logic [PTR_W-1:0] PTR_RST    = 12'h000;

    // ===================================================================
    // Port width codes
    typedef enum logic [WD_W-1:0] {
        FFC_W1  = 3'h0,
        FFC_W2  = 3'h1,
        FFC_W4  = 3'h2,
        FFC_W9  = 3'h3,
        FFC_W18 = 3'h4
    } ffc_width_e;

    // Pointer advance in address bits; nine-bit units count as eight
    function automatic logic [LVL_W-1:0] ffcStep(input ffc_width_e w);
        case (w)
            FFC_W1:  ffcStep = 13'h0001;
            FFC_W2:  ffcStep = 13'h0002;
            FFC_W4:  ffcStep = 13'h0004;
            FFC_W9:  ffcStep = 13'h0008;
            FFC_W18: ffcStep = 13'h0010;
            default: ffcStep = 13'h0001;
        endcase
    endfunction : ffcStep

    // Data bits carried per word
    function automatic logic [4:0] ffcBits(input ffc_width_e w);
        case (w)
            FFC_W1:  ffcBits = 5'h01;
            FFC_W2:  ffcBits = 5'h02;
            FFC_W4:  ffcBits = 5'h04;
            FFC_W9:  ffcBits = 5'h09;
            FFC_W18: ffcBits = 5'h12;
            default: ffcBits = 5'h01;
        endcase
    endfunction : ffcBits

endpackage : ffc_pkg

//--- ffc_link_if.sv
// Interface joining the FIFO controller and the user logic
`timescale 1ns/1ns
interface ffc_link_if;
    import ffc_pkg::*;

    logic [DATA_W-1:0] wrData;
    logic              wrEn;
    logic [DATA_W-1:0] rdData;
    logic              rdEn;
    logic              rdValid;
    logic              full;
    logic              empty;
    logic              almostFullFlag;
    logic              almostEmptyFlag;
    logic [PTR_W-1:0]  almostFullThreshold;
    logic [PTR_W-1:0]  almostEmptyThreshold;
    ffc_width_e        wrWidth;
    ffc_width_e        rdWidth;

    modport dev (
        input  wrData, wrEn, rdEn, almostFullThreshold,
               almostEmptyThreshold, wrWidth, rdWidth,
        output rdData, rdValid, full, empty, almostFullFlag,
               almostEmptyFlag
    );

    modport usr (
        output wrData, wrEn, rdEn, almostFullThreshold,
               almostEmptyThreshold, wrWidth, rdWidth,
        input  rdData, rdValid, full, empty, almostFullFlag,
               almostEmptyFlag
    );

endinterface : ffc_link_if

//--- ffc_stage_fifo.sv
// Small valid/ready FIFO staging write data ahead of the controller
`timescale 1ns/1ns
module ffc_stage_fifo #(
    parameter int unsigned WIDTH = 18,
    parameter int unsigned DEPTH = 8
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    // Fill side
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    // Drain side
    output logic [WIDTH-1:0]      outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wrIdx_q;
    logic [AW-1:0]    rdIdx_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    // Honest flags straight from the occupancy count
    assign inReady  = (count_q != (AW+1)'(DEPTH));
    assign outValid = (count_q != '0);
    assign outData  = mem_q[rdIdx_q];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    // Storage, no reset needed
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wrIdx_q] <= inData;
        end
    end

    // Indices and count; wrap relies on a power-of-two depth
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            wrIdx_q <= '0;
            rdIdx_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wrIdx_q <= wrIdx_q + 1'b1;
            end
            if (pop) begin
                rdIdx_q <= rdIdx_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : ffc_stage_fifo

//--- ffc_controller.sv
// FIFO controller: bit-addressed storage with full, empty and almost flags
`timescale 1ns/1ns
module ffc_controller (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic nrst,
    // User logic side
    ffc_link_if.dev   link
);
    import ffc_pkg::*;

    // ===================================================================
    // State
    logic                   mem_q [MEM_BITS];
    logic [PTR_W-1:0]       writePointer_q;
    logic [PTR_W-1:0]       readPointer_q;
    logic                   phase_q;
    logic [DATA_W-1:0]      rdData_q;
    logic                   rdValid_q;
    logic                   almostFullFlag_q;
    logic                   almostEmptyFlag_q;

    logic [LVL_W-1:0]       wrStep;
    logic [LVL_W-1:0]       rdStep;
    logic [4:0]             wrBits;
    logic [4:0]             rdBits;
    logic [LVL_W-1:0]       level;
    logic [LVL_W-1:0]       freeBits;
    logic [PTR_W-1:0]       ptrDiff;
    logic                   wrOk;
    logic                   rdOk;
    logic [LVL_W-1:0]       wrSum;
    logic [LVL_W-1:0]       rdSum;
    logic [LVL_W-1:0]       level_d;
    logic [IDX_W-1:0]       wrBase;
    logic [IDX_W-1:0]       rdBase;
    logic [IDX_W-1:0]       wrIdx [DATA_W];
    logic [IDX_W-1:0]       rdIdx [DATA_W];

    // ===================================================================
    // Port geometry
    // Only the five native widths exist; one block spans 4096 bits
    // Deeper or wider stores come from several such blocks outside
    assign wrStep = ffcStep(link.wrWidth);
    assign rdStep = ffcStep(link.rdWidth);
    assign wrBits = ffcBits(link.wrWidth);
    assign rdBits = ffcBits(link.rdWidth);

    // ===================================================================
    // Fill level and word-granular flags
    // Difference wraps with the counters; the phase bit tells 0 from 4096
    assign ptrDiff  = writePointer_q - readPointer_q;
    // A borrow out of the twelve-bit difference means the phase bit
    // already counts one wrap of the write pointer
    assign level    = {phase_q ^ (writePointer_q < readPointer_q), ptrDiff};
    assign freeBits = TOTAL_BITS - level;

    // A partial word never moves, so full and empty fire early
    assign link.full  = (freeBits < wrStep);
    assign link.empty = (level < rdStep);

    // Refused requests are simply ignored
    assign wrOk = link.wrEn && !link.full;
    assign rdOk = link.rdEn && !link.empty;

    // ===================================================================
    // Pointer advance
    // Depth in words is 4096 divided by the step: 256 up to 4096
    assign wrSum = {1'b0, writePointer_q} + wrStep;
    assign rdSum = {1'b0, readPointer_q} + rdStep;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            writePointer_q <= PTR_RST;
            readPointer_q  <= PTR_RST;
            phase_q        <= 1'b0;
        end else begin
            if (wrOk) begin
                writePointer_q <= wrSum[PTR_W-1:0];
            end
            if (rdOk) begin
                readPointer_q <= rdSum[PTR_W-1:0];
            end
            // Phase flips on each wrap of either pointer
            phase_q <= phase_q ^ (wrOk && wrSum[PTR_W])
                               ^ (rdOk && rdSum[PTR_W]);
        end
    end

    // ===================================================================
    // Storage mapping
    // Each eight-bit address slot holds nine stored bits, so ninth bits
    // survive while the counters stay twelve bits wide
    assign wrBase = IDX_W'(writePointer_q >> SLOT_SH) * IDX_W'(UNIT_W)
                  + IDX_W'(writePointer_q[SLOT_SH-1:0]);
    assign rdBase = IDX_W'(readPointer_q >> SLOT_SH) * IDX_W'(UNIT_W)
                  + IDX_W'(readPointer_q[SLOT_SH-1:0]);

    // Per-bit addresses; a word starting part-way into the top slot
    // would run off the array, so it folds back to the bottom. Words
    // kept on slot boundaries never fold, save an 18-bit word starting in the top slot
    for (genvar g = 0; g < DATA_W; g++) begin : g_bitAddr
        logic [IDX_W-1:0] wrRaw;
        logic [IDX_W-1:0] rdRaw;
        assign wrRaw    = wrBase + IDX_W'(g);
        assign rdRaw    = rdBase + IDX_W'(g);
        assign wrIdx[g] = (wrRaw >= IDX_W'(MEM_BITS))
                        ? wrRaw - IDX_W'(MEM_BITS) : wrRaw;
        assign rdIdx[g] = (rdRaw >= IDX_W'(MEM_BITS))
                        ? rdRaw - IDX_W'(MEM_BITS) : rdRaw;
    end

    // Write: bit 0 first, so an 18-bit word fills its low unit first
    always_ff @(posedge sys_clk) begin
        if (wrOk) begin
            for (int i = 0; i < DATA_W; i++) begin
                if (5'(i) < wrBits) begin
                    mem_q[wrIdx[i]] <= link.wrData[i];
                end
            end
        end
    end

    // Read data registered, unused upper bits return zero
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rdData_q <= '0;
        end else if (rdOk) begin
            for (int i = 0; i < DATA_W; i++) begin
                if (5'(i) < rdBits) begin
                    rdData_q[i] <= mem_q[rdIdx[i]];
                end else begin
                    rdData_q[i] <= 1'b0;
                end
            end
        end
    end

    // One-cycle strobe marking fresh read data
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rdValid_q <= 1'b0;
        end else begin
            rdValid_q <= rdOk;
        end
    end

    // ===================================================================
    // Almost flags
    // Next level after this cycle's accepted transfers
    always_comb begin
        level_d = level;
        if (wrOk) begin
            level_d = level_d + wrStep;
        end
        if (rdOk) begin
            level_d = level_d - rdStep;
        end
    end

    // Thresholds are bit counts from user logic, compared against the
    // level after the transfer so the flag follows the causing access;
    // being pure level compares, each flag holds until crossed back
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            almostFullFlag_q <= 1'b0;
        end else begin
            almostFullFlag_q <= (level_d >=
                {1'b0, link.almostFullThreshold});
        end
    end

    // Starts set, since an empty store is at or below any threshold
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            almostEmptyFlag_q <= 1'b1;
        end else begin
            almostEmptyFlag_q <= (level_d <=
                {1'b0, link.almostEmptyThreshold});
        end
    end

    // ===================================================================
    // Outputs
    assign link.rdData          = rdData_q;
    assign link.rdValid         = rdValid_q;
    assign link.almostFullFlag  = almostFullFlag_q;
    assign link.almostEmptyFlag = almostEmptyFlag_q;

endmodule : ffc_controller

//--- ffc_user_end.sv
// User-side end: stages writes, issues reads, scales word thresholds
`timescale 1ns/1ns
module ffc_user_end (
    // Clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      nrst,
    // Configuration, thresholds in words
    input  ffc_pkg::ffc_width_e            wrWidth,
    input  ffc_pkg::ffc_width_e            rdWidth,
    input  wire logic [ffc_pkg::PTR_W-1:0] afWords,
    input  wire logic [ffc_pkg::PTR_W-1:0] aeWords,
    // Write stream in
    input  wire logic [ffc_pkg::DATA_W-1:0] inData,
    input  wire logic                      inValid,
    output logic                           inReady,
    // Read stream out
    output logic [ffc_pkg::DATA_W-1:0]     outData,
    output logic                           outValid,
    input  wire logic                      outReady,
    // Status
    output logic                           almostFull,
    output logic                           almostEmpty,
    // Controller side
    ffc_link_if.usr                        link
);
    import ffc_pkg::*;

    logic [DATA_W-1:0] stData;
    logic              stValid;
    logic              stReady;
    logic              pending_q;
    logic [DATA_W-1:0] outData_q;
    logic              outValid_q;
    logic [LVL_W-1:0]  wrStep;
    logic [LVL_W-1:0]  rdStep;

    // ===================================================================
    // Staging buffer; controller full stalls it and reaches inReady
    ffc_stage_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (BUF_DEPTH)
    ) u_stage (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .inData   (inData),
        .inValid  (inValid),
        .inReady  (inReady),
        .outData  (stData),
        .outValid (stValid),
        .outReady (stReady)
    );

    assign stReady     = !link.full;
    assign link.wrEn   = stValid && !link.full;
    assign link.wrData = stData;

    // ===================================================================
    // Threshold scaling: words times the pointer step, so nine and
    // eighteen bit words count as eight and sixteen bits
    assign wrStep = ffcStep(wrWidth);
    assign rdStep = ffcStep(rdWidth);
    assign link.almostFullThreshold  =
        PTR_W'({1'b0, afWords} * wrStep);
    assign link.almostEmptyThreshold =
        PTR_W'({1'b0, aeWords} * rdStep);
    assign link.wrWidth = wrWidth;
    assign link.rdWidth = rdWidth;

    // ===================================================================
    // Reads: one in flight, only while the output holder can take it
    assign link.rdEn = !link.empty && !pending_q
                     && (!outValid_q || outReady);

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            pending_q <= 1'b0;
        end else begin
            pending_q <= link.rdEn;
        end
    end

    // Output holder, data kept until taken
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            outData_q  <= '0;
            outValid_q <= 1'b0;
        end else if (link.rdValid) begin
            outData_q  <= link.rdData;
            outValid_q <= 1'b1;
        end else if (outReady) begin
            outValid_q <= 1'b0;
        end
    end

    assign outData     = outData_q;
    assign outValid    = outValid_q;
    assign almostFull  = link.almostFullFlag;
    assign almostEmpty = link.almostEmptyFlag;

endmodule : ffc_user_end

//--- ffc_link_asserts.sv
// Concurrent checks on the link between controller and user end
`timescale 1ns/1ns
module ffc_link_asserts (
    // Clock and reset
    input wire logic                       sys_clk,
    input wire logic                       nrst,
    // Requests and configuration
    input wire logic                       wrEn,
    input wire logic                       rdEn,
    input ffc_pkg::ffc_width_e             wrWidth,
    input ffc_pkg::ffc_width_e             rdWidth,
    input wire logic [ffc_pkg::PTR_W-1:0]  almostFullThreshold,
    input wire logic [ffc_pkg::PTR_W-1:0]  almostEmptyThreshold,
    // Controller answers
    input wire logic [ffc_pkg::DATA_W-1:0] rdData,
    input wire logic                       rdValid,
    input wire logic                       full,
    input wire logic                       empty,
    input wire logic                       almostFullFlag,
    input wire logic                       almostEmptyFlag
);
    import ffc_pkg::*;

    // ======================================================================
    // Reference fill level
    logic [12:0] lvlQ;
    logic [12:0] lvlD;
    logic [12:0] wrStep;
    logic [12:0] rdStep;
    logic [4:0]  rdBits;

    // Address bits per word; nine-bit units count as eight
    function automatic logic [12:0] stepOf(input logic [2:0] w);
        return (w > 3'h2) ? (13'h0008 << (w - 3'h3)) : (13'h0001 << w);
    endfunction : stepOf

    // Level wraps at 13 bits, so pointer wrap never matters here
    assign wrStep = stepOf(wrWidth);
    assign rdStep = stepOf(rdWidth);
    assign rdBits = (rdWidth > FFC_W4) ? (5'h09 << (rdWidth - FFC_W9))
                                       : rdStep[4:0];
    assign lvlD = lvlQ + ((wrEn && !full) ? wrStep : 13'h0000)
                - ((rdEn && !empty) ? rdStep : 13'h0000);

    // Tracks accepted transfers only, never the design's own counters
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            lvlQ <= 13'h0000;
        end else begin
            lvlQ <= lvlD;
        end
    end

    // ======================================================================
    // Properties
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence s_readTaken;
        rdEn && !empty;
    endsequence
    sequence s_onePulse;
        rdValid ##1 !rdValid;
    endsequence

    property p_readAnswer;
        s_readTaken |=> s_onePulse;
    endproperty
    a_readAnswer: assert property (p_readAnswer)
        else $error("read not answered by a single valid pulse");

    property p_noSpurious;
        !(rdEn && !empty) |=> !rdValid;
    endproperty
    a_noSpurious: assert property (p_noSpurious)
        else $error("read data valid without an accepted read");

    // Flags lag the causing transfer by one edge
    property p_almostFull;
        $past(nrst) |-> almostFullFlag ==
            (lvlQ >= {1'b0, $past(almostFullThreshold)});
    endproperty
    a_almostFull: assert property (p_almostFull)
        else $error("almost full flag disagrees with level");

    property p_almostEmpty;
        $past(nrst) |-> almostEmptyFlag ==
            (lvlQ <= {1'b0, $past(almostEmptyThreshold)});
    endproperty
    a_almostEmpty: assert property (p_almostEmpty)
        else $error("almost empty flag disagrees with level");

    property p_full;
        full == ((13'h1000 - lvlQ) < wrStep);
    endproperty
    a_full: assert property (p_full)
        else $error("full flag wrong for free space");

    property p_empty;
        empty == (lvlQ < rdStep);
    endproperty
    a_empty: assert property (p_empty)
        else $error("empty flag wrong for stored bits");

    property p_dataHold;
        $changed(rdData) |-> rdValid;
    endproperty
    a_dataHold: assert property (p_dataHold)
        else $error("read data changed without a read");

    property p_unusedZero;
        rdValid |-> (rdData >> rdBits) == '0;
    endproperty
    a_unusedZero: assert property (p_unusedZero)
        else $error("read data bits above the width not zero");

endmodule : ffc_link_asserts

//--- tb.sv
// Self-checking bench for the FIFO controller and its user end
`timescale 1ns/1ns
module tb;
    import ffc_pkg::*;

    // ======================================================================
    // Stimulus and bookkeeping
    localparam int NW = 1033; // Words held: core, read holder, stage
    localparam int STEPS [5] = '{1, 2, 4, 8, 16};
    localparam int BITS  [5] = '{1, 2, 4, 9, 18};
    logic              sys_clk     = 1'b0;
    logic              nrst        = 1'b0;
    ffc_width_e        wrWidth     = FFC_W4;
    ffc_width_e        rdWidth     = FFC_W4;
    logic [PTR_W-1:0]  afWords     = 12'h006;
    logic [PTR_W-1:0]  aeWords     = 12'h001;
    logic [DATA_W-1:0] inData      = 18'h00000;
    logic              inValid     = 1'b0;
    logic              outReady    = 1'b0;
    logic              inReady;
    logic [DATA_W-1:0] outData;
    logic              outValid;
    logic              almostFull;
    logic              almostEmpty;
    logic [DATA_W-1:0] mask;
    int                errors      = 0;
    int                n_compared  = 0;
    int                cycles      = 0;
    int                i;

    // Free-running clock at 50 ns
    always #25 sys_clk = ~sys_clk;

    ffc_link_if link ();
    ffc_controller u_ffc_controller (.sys_clk(sys_clk), .nrst(nrst),
        .link(link));
    ffc_user_end u_ffc_user_end (.sys_clk(sys_clk), .nrst(nrst),
        .wrWidth(wrWidth), .rdWidth(rdWidth), .afWords(afWords),
        .aeWords(aeWords), .inData(inData), .inValid(inValid),
        .inReady(inReady), .outData(outData), .outValid(outValid),
        .outReady(outReady), .almostFull(almostFull),
        .almostEmpty(almostEmpty), .link(link));
    ffc_link_asserts u_ffc_link_asserts (.sys_clk(sys_clk), .nrst(nrst),
        .wrEn(link.wrEn), .rdEn(link.rdEn), .wrWidth(link.wrWidth),
        .rdWidth(link.rdWidth),
        .almostFullThreshold(link.almostFullThreshold),
        .almostEmptyThreshold(link.almostEmptyThreshold),
        .rdData(link.rdData), .rdValid(link.rdValid), .full(link.full),
        .empty(link.empty), .almostFullFlag(link.almostFullFlag),
        .almostEmptyFlag(link.almostEmptyFlag));

    // ======================================================================
    // Tasks
    task automatic check(input logic [DATA_W-1:0] seen,
                         input logic [DATA_W-1:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t ns: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask : check

    task automatic idle(input int k);
        repeat (k) @(negedge sys_clk);
    endtask : idle

    task automatic rst();
        nrst = 1'b0;
        repeat (6) @(negedge sys_clk);
        nrst = 1'b1;
        @(negedge sys_clk);
    endtask : rst

    // Leaves valid high so back-to-back beats stay back to back
    task automatic push(input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        inData = d;
        inValid = 1'b1;
        while (inReady !== 1'b1 && n < 200) begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 200) check(1'b0, 1'b1, "write beat not taken");
        @(negedge sys_clk);
    endtask : push

    task automatic pull(input logic [DATA_W-1:0] exp);
        int n;
        n = 0;
        while (outValid !== 1'b1 && n < 200) begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 200) check(1'b0, 1'b1, "read word never came");
        check(outData, exp, "read word");
        outReady = 1'b1;
        @(negedge sys_clk);
        outReady = 1'b0;
    endtask : pull

    task automatic wrap_up();
        $display("Compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    // Hang guard well above the few thousand cycles needed
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            $display("[FAIL] %0t ns: run did not finish", $time);
            wrap_up();
        end
    end

    // ======================================================================
    // Tests
    initial begin
        rst();
        // Fill until refused with reader stalled, then drain
        for (i = 0; i < NW; i++) begin
            push(DATA_W'((i + 1) & 15));
            if (i == 5 || i == 6) begin
                inValid = 1'b0;
                idle(4);
                check(almostFull, DATA_W'(i == 6), "upper flag");
                check(almostEmpty, 18'h0, "lower flag");
            end
        end
        inValid = 1'b0;
        idle(6);
        check(inReady, 18'h0, "stage refusal");
        check(link.full, 18'h1, "full");
        for (i = 0; i < NW; i++) begin
            if (i >= NW - 7) begin
                idle(3);
                check(almostFull, DATA_W'(i == NW - 7), "upper");
                check(almostEmpty, DATA_W'(i >= NW - 2), "lower");
            end
            pull(DATA_W'((i + 1) & 15));
        end
        idle(4);
        check(link.empty, 18'h1, "empty");
        $display("Test 1 done");
        // Wide write, narrow read
        rdWidth = FFC_W2;
        rst();
        check(link.almostFullThreshold, 18'd24, "write scale");
        check(link.almostEmptyThreshold, 18'd2, "read scale");
        push(18'h00006);
        inValid = 1'b0;
        pull(18'h00002);
        pull(18'h00001);
        for (i = 0; i < 1032; i++) push(18'h00005);
        inValid = 1'b0;
        idle(6);
        check(link.full, 18'h1, "full after narrow read");
        check(outValid, 18'h1, "narrow word held");
        $display("Test 2 done");
        // Narrow write, wide read
        wrWidth = FFC_W2;
        rdWidth = FFC_W4;
        rst();
        push(18'h00001);
        inValid = 1'b0;
        idle(4);
        check(link.empty, 18'h1, "half word");
        check(outValid, 18'h0, "no half word");
        push(18'h00002);
        inValid = 1'b0;
        pull(18'h00009);
        $display("Test 3 done");
        // Every port width, thresholds in bits
        afWords = 12'h003;
        aeWords = 12'h002;
        for (i = 0; i < 5; i++) begin
            wrWidth = ffc_width_e'(i);
            rdWidth = ffc_width_e'(i);
            mask = DATA_W'((1 << BITS[i]) - 1);
            idle(2);
            check(link.almostFullThreshold, DATA_W'(3 * STEPS[i]), "af");
            check(link.almostEmptyThreshold, DATA_W'(2 * STEPS[i]), "ae");
            push(18'h2b5a7 & mask);
            push(~18'h2b5a7 & mask);
            inValid = 1'b0;
            pull(18'h2b5a7 & mask);
            pull(~18'h2b5a7 & mask);
        end
        $display("Test 4 done");
        wrap_up();
    end

endmodule : tb
